// [src/ifb_pkg.sv]
// package: register map, field layouts and types of the flag/enable bank
package ifb_pkg;

  localparam int unsigned IFB_DW = 16;
  localparam int unsigned IFB_AW = 4;

  // register offsets (word index on the register port)
  localparam logic [3:0] IFB_OFS_FLAGS2 = 4'h0;
  localparam logic [3:0] IFB_OFS_EN0    = 4'h1;
  localparam logic [3:0] IFB_OFS_EN1    = 4'h2;
  localparam logic [3:0] IFB_OFS_EN2    = 4'h3;
  localparam logic [3:0] IFB_OFS_ISTAT  = 4'h4;
  localparam logic [3:0] IFB_OFS_IMASK  = 4'h5;
  localparam logic [3:0] IFB_OFS_PEND2  = 4'h6;

  // implemented-bit masks
  localparam logic [15:0] IFB_MSK_BANK2 = 16'h07E1;
  localparam logic [15:0] IFB_MSK_EN0   = 16'h7FEF;
  localparam logic [15:0] IFB_MSK_EN1   = 16'hE87F;
  localparam logic [15:0] IFB_MSK_IRQ   = 16'h0003;

  // field positions, bank 2
  localparam int unsigned IFB_POS_CMP4  = 0;
  localparam int unsigned IFB_POS_PAIR0 = 5;
  localparam int unsigned IFB_NPAIRS    = 6;

  // interrupt status bits of this block
  localparam int unsigned IFB_IRQ_PEND  = 0;
  localparam int unsigned IFB_IRQ_FORCE = 1;

  localparam logic [15:0] IFB_RST_REG   = 16'h0000;

  typedef enum logic [2:0] {
    IFB_BUS_IDLE  = 3'b001,
    IFB_BUS_WRITE = 3'b010,
    IFB_BUS_READ  = 3'b100
  } ifb_bus_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } ifb_req_t;

  typedef struct packed {
    logic [5:0] pair_done;
    logic       cmp4;
  } ifb_evt_t;

endpackage

// [src/ifb_flag_bit.sv]
// one sticky request flag: event sets, software writes
`timescale 1ns/1ps
`default_nettype none
module ifb_flag_bit
  import ifb_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic evt,
  input  wire logic wr,
  input  wire logic wval,
  output var  logic flag_ff
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (ce) begin
      if (evt) begin
        flag_ff <= 1'b1;
      end else if (wr) begin
        flag_ff <= wval;
      end
    end
  end
endmodule
`default_nettype wire

// [src/ifb_en_reg.sv]
// software-written enable register with implemented-bit mask
`timescale 1ns/1ps
`default_nettype none
module ifb_en_reg
  import ifb_pkg::*;
#(
  parameter logic [15:0] MASK = 16'hFFFF
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        wr,
  input  wire logic [15:0] wdata,
  output var  logic [15:0] q_ff
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= IFB_RST_REG;
    end else if (ce && wr) begin
      q_ff <= wdata & MASK;
    end
  end
endmodule
`default_nettype wire

// [src/ifb_top.sv]
// flag bank 2 and enable banks 0..2 with register port and interrupt
//
// Behaviour
// - flag reads 1 after its source requested, 0 if no request.
// - enable bit 1 passes the source request, 0 blocks it.
// - bank2 flags: bits 10..5 converter pairs 5..0, bit 0 comparator 4.
// - bank2 flag/enable bits 15..11 and 4..1 always read zero.
// - enable0 bits 14..8 two-wire, memory, converter, serial, sync port.
// - enable0 bits 7..5 and 3..0 timers, compares, capture, pin 0.
// - enable1 bits 15..13 comparators 3..1, bit 11 change notify.
// - enable1 bits 6..3 pulse gens 4..1, bit 2 event match, 1..0 pins.
// - enable2 bits 10..5 converter pairs 5..0, bit 0 comparator 4.
// - all implemented flag and enable bits clear at reset.
// - software reads and writes every implemented flag and enable bit.
`timescale 1ns/1ps
`default_nettype none
module ifb_top
  import ifb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  input  wire logic [5:0]  pair_done_evt,
  input  wire logic        cmp4_evt,
  output logic      [15:0] rdata,
  output logic      [15:0] pend2,
  output logic      [15:0] en0,
  output logic      [15:0] en1,
  output logic             irq
);

  // ---------------------------------------------------------------
  // request decode
  // ---------------------------------------------------------------
  ifb_req_t req;
  ifb_evt_t evt;
  ifb_bus_t bus_st;
  logic     wr_flags2;
  logic     wr_en0;
  logic     wr_en1;
  logic     wr_en2;
  logic     wr_imask;

  assign req = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wdata};
  assign evt = '{pair_done: pair_done_evt, cmp4: cmp4_evt};

  assign bus_st = req.wr ? IFB_BUS_WRITE :
                  req.rd ? IFB_BUS_READ  : IFB_BUS_IDLE;

  always_comb begin
    wr_flags2 = 1'b0;
    wr_en0    = 1'b0;
    wr_en1    = 1'b0;
    wr_en2    = 1'b0;
    wr_imask  = 1'b0;
    if (bus_st == IFB_BUS_WRITE) begin
      if (req.addr == IFB_OFS_FLAGS2) begin
        wr_flags2 = 1'b1;
      end else if (req.addr == IFB_OFS_EN0) begin
        wr_en0 = 1'b1;
      end else if (req.addr == IFB_OFS_EN1) begin
        wr_en1 = 1'b1;
      end else if (req.addr == IFB_OFS_EN2) begin
        wr_en2 = 1'b1;
      end else if (req.addr == IFB_OFS_IMASK) begin
        wr_imask = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // flag bank 2
  // ---------------------------------------------------------------
  logic [15:0] flags2;
  logic [15:0] evt_vec;

  always_comb begin
    evt_vec = 16'h0000;
    evt_vec[IFB_POS_CMP4] = evt.cmp4;
    evt_vec[IFB_POS_PAIR0 +: IFB_NPAIRS] = evt.pair_done;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_flag
      if (IFB_MSK_BANK2[gi]) begin : g_impl
        ifb_flag_bit u_flag (
          .clk     (clk),
          .rst     (rst),
          .ce      (ce),
          .evt     (evt_vec[gi]),
          .wr      (wr_flags2),
          .wval    (req.wdata[gi]),
          .flag_ff (flags2[gi])
        );
      end else begin : g_none
        assign flags2[gi] = 1'b0;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // enable banks
  // ---------------------------------------------------------------
  logic [15:0] en0_ff;
  logic [15:0] en1_ff;
  logic [15:0] en2_ff;

  ifb_en_reg #(.MASK(IFB_MSK_EN0)) u_en0 (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .wr    (wr_en0),
    .wdata (req.wdata),
    .q_ff  (en0_ff)
  );

  ifb_en_reg #(.MASK(IFB_MSK_EN1)) u_en1 (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .wr    (wr_en1),
    .wdata (req.wdata),
    .q_ff  (en1_ff)
  );

  ifb_en_reg #(.MASK(IFB_MSK_BANK2)) u_en2 (
    .clk   (clk),
    .rst   (rst),
    .ce    (ce),
    .wr    (wr_en2),
    .wdata (req.wdata),
    .q_ff  (en2_ff)
  );

  // ---------------------------------------------------------------
  // pending to vectoring logic, registered outputs
  // ---------------------------------------------------------------
  logic [15:0] nxt_pend2;
  logic [15:0] pend2_ff;
  logic [15:0] en0_out_ff;
  logic [15:0] en1_out_ff;

  assign nxt_pend2 = flags2 & en2_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend2_ff   <= IFB_RST_REG;
      en0_out_ff <= IFB_RST_REG;
      en1_out_ff <= IFB_RST_REG;
    end else if (ce) begin
      pend2_ff   <= nxt_pend2;
      en0_out_ff <= en0_ff;
      en1_out_ff <= en1_ff;
    end
  end

  assign pend2 = pend2_ff;
  assign en0   = en0_out_ff;
  assign en1   = en1_out_ff;

  // ---------------------------------------------------------------
  // block interrupt: status, mask, level output
  // ---------------------------------------------------------------
  logic [15:0] istat_ff;
  logic [15:0] imask_ff;
  logic [15:0] irq_evt;
  logic        rd_istat;
  logic        irq_ff;

  assign rd_istat = (bus_st == IFB_BUS_READ) && (req.addr == IFB_OFS_ISTAT);

  always_comb begin
    irq_evt = 16'h0000;
    irq_evt[IFB_IRQ_PEND]  = |(nxt_pend2 & ~pend2_ff);
    irq_evt[IFB_IRQ_FORCE] = wr_flags2 && |(req.wdata & IFB_MSK_BANK2);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      istat_ff <= IFB_RST_REG;
    end else if (ce) begin
      // a new event beats the clear-on-read
      istat_ff <= (rd_istat ? 16'h0000 : istat_ff) | irq_evt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      imask_ff <= IFB_RST_REG;
    end else if (ce && wr_imask) begin
      imask_ff <= req.wdata & IFB_MSK_IRQ;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(((rd_istat ? 16'h0000 : istat_ff) | irq_evt) & imask_ff);
    end
  end

  assign irq = irq_ff;

  // ---------------------------------------------------------------
  // read port, data one cycle after strobe
  // ---------------------------------------------------------------
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;

  always_comb begin
    nxt_rdata = 16'h0000;
    if (bus_st == IFB_BUS_READ) begin
      if (req.addr == IFB_OFS_FLAGS2) begin
        nxt_rdata = flags2 & IFB_MSK_BANK2;
      end else if (req.addr == IFB_OFS_EN0) begin
        nxt_rdata = en0_ff;
      end else if (req.addr == IFB_OFS_EN1) begin
        nxt_rdata = en1_ff;
      end else if (req.addr == IFB_OFS_EN2) begin
        nxt_rdata = en2_ff;
      end else if (req.addr == IFB_OFS_ISTAT) begin
        nxt_rdata = istat_ff;
      end else if (req.addr == IFB_OFS_IMASK) begin
        nxt_rdata = imask_ff;
      end else if (req.addr == IFB_OFS_PEND2) begin
        nxt_rdata = pend2_ff;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= IFB_RST_REG;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata = rdata_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_evt_sets;
    @(posedge clk) disable iff (rst)
      (ce && evt.cmp4) |=> flags2[IFB_POS_CMP4];
  endproperty
  a_evt_sets: assert property (p_evt_sets)
    else $error("event did not set flag");
  property p_pair_map;
    @(posedge clk) disable iff (rst)
      (ce && evt.pair_done[5]) |=> flags2[10];
  endproperty
  a_pair_map: assert property (p_pair_map)
    else $error("pair 5 flag not at bit 10");
  property p_unimpl;
    @(posedge clk) disable iff (rst)
      ((flags2 | en2_ff) & ~IFB_MSK_BANK2) == 16'h0000;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bank2 bit set");
  property p_en0_hole;
    @(posedge clk) disable iff (rst)
      (en0_ff[15] == 1'b0) && (en0_ff[4] == 1'b0);
  endproperty
  a_en0_hole: assert property (p_en0_hole)
    else $error("enable0 reserved bit set");
  property p_en1_hole;
    @(posedge clk) disable iff (rst)
      (en1_ff[12] == 1'b0) && (en1_ff[10:7] == 4'h0);
  endproperty
  a_en1_hole: assert property (p_en1_hole)
    else $error("enable1 reserved bit set");
  property p_pend;
    @(posedge clk) disable iff (rst)
      ce |=> (pend2_ff == $past(flags2 & en2_ff));
  endproperty
  a_pend: assert property (p_pend)
    else $error("pending not flag and enable");
  property p_hold;
    @(posedge clk) disable iff (rst)
      (ce && !wr_flags2 && flags2[IFB_POS_CMP4]) |=> flags2[IFB_POS_CMP4];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without write");

  property p_clear;
    @(posedge clk) disable iff (rst)
      (ce && wr_flags2 && !req.wdata[0] && !evt.cmp4) |=> !flags2[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("software clear failed");

  property p_rd_en1;
    @(posedge clk) disable iff (rst)
      (ce && rd_stb && !wr_stb && addr == IFB_OFS_EN1) |=>
        (rdata == $past(en1_ff));
  endproperty
  a_rd_en1: assert property (p_rd_en1)
    else $error("enable1 readback wrong");

  property p_wr_en2;
    @(posedge clk) disable iff (rst)
      (ce && wr_en2) |=> (en2_ff == ($past(wdata) & IFB_MSK_BANK2));
  endproperty
  a_wr_en2: assert property (p_wr_en2)
    else $error("enable2 write wrong");

  property p_wr_en0;
    @(posedge clk) disable iff (rst)
      (ce && wr_en0) ##1 ce |=> (en0 == ($past(wdata, 2) & IFB_MSK_EN0));
  endproperty
  a_wr_en0: assert property (p_wr_en0)
    else $error("enable0 output wrong");

  property p_block;
    @(posedge clk) disable iff (rst)
      (ce && !en2_ff[0]) |=> !pend2_ff[0];
  endproperty
  a_block: assert property (p_block)
    else $error("disabled source pending");

  c_evt:   cover property (@(posedge clk) ce && evt.cmp4);
  c_pend:  cover property (@(posedge clk) pend2_ff != 16'h0000);
  c_irq:   cover property (@(posedge clk) irq_ff);
  c_clear: cover property (@(posedge clk) wr_flags2 && flags2 != 16'h0000);

endmodule
`default_nettype wire

// [sim/ifb_evt_src.sv]
// event source model: converter pairs and comparator 4
`timescale 1ns/1ps
`default_nettype none
module ifb_evt_src
  import ifb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire ifb_evt_t   fire,
  input  wire logic [1:0] hold,
  output var  logic [5:0] pair_done_evt,
  output var  logic       cmp4_evt
);
  ifb_evt_t   cur_ff;
  logic [1:0] cnt_ff;

  // pulse or held level, hold+1 cycles long
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_ff <= '0;
      cnt_ff <= 2'h0;
    end else if (fire != '0) begin
      cur_ff <= fire;
      cnt_ff <= hold;
    end else if (cnt_ff != 2'h0) begin
      cnt_ff <= cnt_ff - 2'h1;
    end else begin
      cur_ff <= '0;
    end
  end

  assign pair_done_evt = cur_ff.pair_done;
  assign cmp4_evt      = cur_ff.cmp4;
endmodule
`default_nettype wire

// [sim/ifb_top_test.sv]
// self-checking bench of the flag/enable bank with reference model
`timescale 1ns/1ps
`default_nettype none
module ifb_top_test
  import ifb_pkg::*;
;
  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        ce     = 1'b1;
  logic [3:0]  addr   = 4'h0;
  logic [15:0] wdata  = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  ifb_evt_t    fire   = '0;
  logic [1:0]  hold   = 2'h0;
  logic [5:0]  pair_done_evt;
  logic        cmp4_evt;
  logic [15:0] rdata, pend2, en0, en1, last_rd;
  logic        irq;
  logic [31:0] lfsr_st = 32'hE6CCBE1D;
  logic        dc = 1'b0;
  int          error_cnt = 0;
  int          check_count = 0;
  int          m_fl, m_e0, m_e1, m_e2, m_mk, x_rd, x_p2, x_e0, x_e1;

  always #10 clk = ~clk;

  ifb_top ifb_top_i (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .pair_done_evt(pair_done_evt), .cmp4_evt(cmp4_evt), .rdata(rdata),
    .pend2(pend2), .en0(en0), .en1(en1), .irq(irq));

  ifb_evt_src ifb_evt_src_i (.clk(clk), .rst(rst), .fire(fire),
    .hold(hold), .pair_done_evt(pair_done_evt), .cmp4_evt(cmp4_evt));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [15:0] seen, input int exp);
    check_count++;
    if (seen !== exp[15:0]) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp[15:0]);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // bus and event drivers, one clock per cyc, wr or rd call, n clocks per idle(n)
  // ---------------------------------------------------------------
  task automatic cyc(input logic w, input logic r, input logic [3:0] a,
                     input logic [15:0] d, input ifb_evt_t f,
                     input logic [1:0] h);
    wr_stb <= w;
    rd_stb <= r;
    addr   <= a;
    wdata  <= d;
    fire   <= f;
    hold   <= h;
    @(posedge clk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    cyc(1'b1, 1'b0, a, d, '0, 2'h0);
  endtask

  task automatic rd(input logic [3:0] a);
    cyc(1'b0, 1'b1, a, 16'h0000, '0, 2'h0);
  endtask

  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 4'h0, 16'h0000, '0, 2'h0);
  endtask

  task automatic zero_scan();
    for (int i = 0; i < 16; i++) if (i != 4 && i != 6) rd(i[3:0]);
    idle(2);
    check({15'h0000, irq}, 0);
  endtask

  // ---------------------------------------------------------------
  // reference model, compared at every result except istat reads and irq
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {m_fl, m_e0, m_e1, m_e2, m_mk} = '0;
      {x_rd, x_p2, x_e0, x_e1} = '0;
      dc = 1'b0;
    end else if (ce) begin
      if (!dc) check(rdata, x_rd);
      else last_rd = rdata;
      check(pend2, x_p2);
      check(en0, x_e0);
      check(en1, x_e1);
      x_e0 = m_e0;
      x_e1 = m_e1;
      x_rd = 0;
      dc = 1'b0;
      if (rd_stb) case (addr)
        IFB_OFS_FLAGS2: x_rd = m_fl;
        IFB_OFS_EN0:    x_rd = m_e0;
        IFB_OFS_EN1:    x_rd = m_e1;
        IFB_OFS_EN2:    x_rd = m_e2;
        IFB_OFS_IMASK:  x_rd = m_mk;
        IFB_OFS_PEND2:  x_rd = x_p2;
        IFB_OFS_ISTAT:  dc = 1'b1;
        default:        x_rd = 0;
      endcase
      x_p2 = m_fl & m_e2;
      if (wr_stb) case (addr)
        IFB_OFS_FLAGS2: m_fl = wdata & IFB_MSK_BANK2;
        IFB_OFS_EN0:    m_e0 = wdata & IFB_MSK_EN0;
        IFB_OFS_EN1:    m_e1 = wdata & IFB_MSK_EN1;
        IFB_OFS_EN2:    m_e2 = wdata & IFB_MSK_BANK2;
        IFB_OFS_IMASK:  m_mk = wdata & IFB_MSK_IRQ;
        default:        ;
      endcase
      m_fl = m_fl | (pair_done_evt << IFB_POS_PAIR0) | cmp4_evt;
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    zero_scan();
    for (int i = 0; i < 4; i++) wr(i[3:0], 16'hFFFF);
    for (int i = 0; i < 4; i++) rd(i[3:0]);
    wr(IFB_OFS_FLAGS2, 16'h0000);
    wr(IFB_OFS_EN2, 16'h0000);
    // each source sets its flag with its enable off
    for (int i = 0; i < 7; i++) begin
      cyc(1'b0, 1'b0, 4'h0, 16'h0000, ifb_evt_t'(7'h01 << i), 2'h0);
      idle(3);
      rd(IFB_OFS_FLAGS2);
    end
    wr(IFB_OFS_EN2, 16'hFFFF);
    idle(3);
    // clear written on the same edge as an event
    cyc(1'b0, 1'b0, 4'h0, 16'h0000, ifb_evt_t'(7'h40), 2'h0);
    wr(IFB_OFS_FLAGS2, 16'h0000);
    rd(IFB_OFS_FLAGS2);
    wr(IFB_OFS_FLAGS2, 16'h0000);
    idle(4);
    rd(IFB_OFS_FLAGS2);
    // interrupt raised, read-cleared, masked
    wr(IFB_OFS_EN2, 16'h0001);
    wr(IFB_OFS_IMASK, 16'h0001);
    rd(IFB_OFS_ISTAT);
    idle(3);
    check({15'h0000, irq}, 0);
    cyc(1'b0, 1'b0, 4'h0, 16'h0000, ifb_evt_t'(7'h01), 2'h1);
    idle(5);
    check({15'h0000, irq}, 1);
    rd(IFB_OFS_ISTAT);
    idle(2);
    check(last_rd & 16'h0001, 1);
    idle(2);
    check({15'h0000, irq}, 0);
    wr(IFB_OFS_IMASK, 16'h0002);
    wr(IFB_OFS_FLAGS2, 16'h0020);
    idle(3);
    check({15'h0000, irq}, 1);
    rd(IFB_OFS_ISTAT);
    idle(3);
    check({15'h0000, irq}, 0);
    wr(IFB_OFS_IMASK, 16'h0000);
    // random traffic with clock-enable gaps
    for (int i = 0; i < 400; i++) begin
      lfsr_st = lfsr(lfsr_st);
      ce <= (lfsr_st[2:0] != 3'h0);
      cyc(lfsr_st[4:3] == 2'h1, lfsr_st[4:3] == 2'h2,
          {lfsr_st[8] & lfsr_st[9], lfsr_st[7:5]}, lfsr_st[31:16],
          ifb_evt_t'(lfsr_st[15:9] & lfsr_st[24:18]), lfsr_st[26:25]);
    end
    ce <= 1'b1;
    idle(4);
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    zero_scan();
    end_sim();
  end

  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
endmodule
`default_nettype wire
